// ### prst_consts.vh
// Constants for the port readback self-test block: register offsets,
// field positions and reset values. Definitions only.
`ifndef PRST_CONSTS_VH
`define PRST_CONSTS_VH
`define PRST_KEY_PATTERN 8'hca
`define PRST_KEY_RESET 8'h00
`define PRST_PORT_RESET 8'hff
`define PRST_OFS_KEY 4'h0
`define PRST_OFS_DATA 4'h1
`define PRST_OFS_DIR 4'h2
`define PRST_OFS_PIN 4'h3
`define PRST_OFS_READ 4'h4
`define PRST_OFS_BITOP 4'h5
`define PRST_OFS_ANSEL 4'h6
`define PRST_OFS_FUNC 4'h7
`define PRST_OFS_CHAN 4'h8
`define PRST_OFS_WKEN 4'h9
`define PRST_OFS_STAT 4'ha
`define PRST_OFS_MASK 4'hb
`define PRST_OFS_SLEEP 4'hc
`define PRST_BITOP_SET 3
`define PRST_STAT_WAKE 0
`define PRST_STAT_KEYCHG 1
`endif

// ### prst_pin_read.v
// Read mux for one pin: chooses what a port read returns.
// Assumes all inputs are synchronous to the system clock.
`timescale 1ns/1ps
module prst_pin_read (
    input wire readback_enable_i,
    input wire pin_i,
    input wire latch_i,
    input wire dir_i,
    input wire analog_i,
    input wire serial_i,
    output reg value_o
);
    // Readback returns the pin; otherwise per pin function
    always @* begin
        if (readback_enable_i) begin
            value_o = pin_i;
        end else if (analog_i) begin
            value_o = 1'b0;
        end else if (serial_i || dir_i) begin
            value_o = pin_i;
        end else begin
            value_o = latch_i;
        end
    end
endmodule

// ### prst_ana_sw.v
// Analog path switch control for one pin.
// Assumes channel select and function bits come from registers.
`timescale 1ns/1ps
module prst_ana_sw (
    input wire readback_enable_i,
    input wire chan_sel_i,
    input wire ana_func_i,
    output wire close_o
);
    // Readback forces the chosen channel closed for self test
    assign close_o = chan_sel_i & (ana_func_i | readback_enable_i);
endmodule

// ### prst_top.v
// Port readback self-test block: one 8-bit port with readback mode,
// analog path control, bit set/clear and wake-up on falling edges.
// Assumes a classic Wishbone master and pins synchronous to clk_i.
//
// Operation
// - Readback is enabled only while the key register holds 11001010.
// - With readback enabled a port read returns the real pin levels.
// - With readback disabled each pin behaves as its chosen function.
// - Disabled, a plain digital pin reads its latch when direction is 0, else the pin level.
// - Disabled, an analog path closes only if its function and channel are chosen.
// - Enabled, the chosen channel's analog path closes whatever its function.
// - Any reset sets data and direction registers to all ones.
// - A bit set or clear reads the port, changes one bit and writes the byte back.
// - In sleep, a falling edge on an enabled pin wakes the device.
//
// Register map (word index, byte address = index * 4):
//   0 readback key, any byte stored, decoded continuously
//   1 port data latch
//   2 port direction, 1 = input
//   3 raw pin levels, read only
//   4 port read value as an instruction would see it, read only
//   5 bit op: [2:0] bit number, [3] 1 sets, 0 clears
//   6 analog function select per pin
//   7 serial function select per pin
//   8 converter channel select, one-hot
//   9 wake enable per pin
//   a status, write one to clear: [0] wake, [1] key written
//   b interrupt mask, same layout as status
//   c sleep, write 1 to sleep, cleared by a wake event
//
// Bus timing: a request is taken at the first edge with cyc and stb high and
// ack low; ack follows for exactly one cycle and read data stands with it.
// Derived outputs (pins, analog switches, enable flag) follow one edge after
// the write that changes them.
// A bit op changes the addressed bit in the value a port read returns at the
// next edge and writes the whole byte to the data latch.
// Limitations: one port is modelled; the converter channel select is a
// plain one-hot register rather than a decoded channel number.
`timescale 1ns/1ps
`include "prst_consts.vh"
module prst_top #(
    parameter WIDTH = 8
) (
    input wire clk_i,
    input wire rst_i,
    input wire wb_cyc_i,
    input wire wb_stb_i,
    input wire wb_we_i,
    input wire [5:0] wb_adr_i,
    input wire [3:0] wb_sel_i,
    input wire [31:0] wb_dat_i,
    output reg [31:0] wb_dat_o,
    output reg wb_ack_o,
    input wire [WIDTH-1:0] pin_i,
    output reg [WIDTH-1:0] pin_o,
    output reg [WIDTH-1:0] pin_oe_o,
    output reg [WIDTH-1:0] ana_close_o,
    output reg readback_enable_o,
    output reg wake_o,
    output reg irq_o
);
    // Control and status registers
    reg [7:0] readback_key_r;
    reg [WIDTH-1:0] port_data_register_r;
    reg [WIDTH-1:0] port_direction_r;
    reg [WIDTH-1:0] ansel_r;
    reg [WIDTH-1:0] serial_r;
    reg [WIDTH-1:0] chan_sel_r;
    reg [WIDTH-1:0] wake_en_r;
    reg [WIDTH-1:0] pin_prev_r;
    reg [1:0] stat_r;
    reg [1:0] mask_r;
    reg sleep_r;
    reg [2:0] bit_idx_r;
    reg bit_set_r;
    reg [3:0] op_r;
    reg bitop_pend_r;
    // Decode nets and per-pin results
    wire [WIDTH-1:0] read_val;
    wire [WIDTH-1:0] close_w;
    wire readback_enable;
    wire [3:0] reg_idx;
    wire acc_go;
    wire wr_go;
    wire [WIDTH-1:0] fall;
    wire wake_evt;
    wire keychg_evt;
    // Combinational helpers
    reg [WIDTH-1:0] rmw_val;
    reg [31:0] rd_nxt;
    reg [1:0] stat_nxt;

    // Key decode is combinational on the stored byte, so the enable follows
    // every key write at once; a near miss of the pattern keeps it low and
    // no partial key can open the readback path
    assign readback_enable = (readback_key_r == `PRST_KEY_PATTERN);
    assign reg_idx = wb_adr_i[5:2];
    assign acc_go = wb_cyc_i && wb_stb_i && !wb_ack_o;
    assign wr_go = acc_go && wb_we_i && wb_sel_i[0];
    assign fall = pin_prev_r & ~pin_i & wake_en_r;
    assign wake_evt = sleep_r && (|fall);
    assign keychg_evt = wr_go && (reg_idx == `PRST_OFS_KEY);

    // Per-pin read mux and analog switch; one small module each, repeated
    // for every pin so the per-pin behaviour is written and checked once
    // Per-pin read mux and analog switch
    genvar g;
    generate
        for (g = 0; g < WIDTH; g = g + 1) begin : g_pin
            prst_pin_read u_rd (
                .readback_enable_i(readback_enable),
                .pin_i(pin_i[g]),
                .latch_i(port_data_register_r[g]),
                .dir_i(port_direction_r[g]),
                .analog_i(ansel_r[g]),
                .serial_i(serial_r[g]),
                .value_o(read_val[g])
            );
            prst_ana_sw u_sw (
                .readback_enable_i(readback_enable),
                .chan_sel_i(chan_sel_r[g]),
                .ana_func_i(ansel_r[g]),
                .close_o(close_w[g])
            );
        end
    endgenerate

    // Bit op: modify the value a port read returns, one bit, full byte back
    always @* begin
        rmw_val = read_val;
        rmw_val[bit_idx_r] = bit_set_r;
    end

    // Sticky status: a set in the same cycle as a clear wins
    always @* begin
        stat_nxt = stat_r;
        if (wr_go && reg_idx == `PRST_OFS_STAT) begin
            stat_nxt = stat_r & ~wb_dat_i[1:0];
        end
        if (wake_evt) begin
            stat_nxt[`PRST_STAT_WAKE] = 1'b1;
        end
        if (keychg_evt) begin
            stat_nxt[`PRST_STAT_KEYCHG] = 1'b1;
        end
    end

    // Read data mux; unmapped offsets read zero
    always @* begin
        rd_nxt = 32'h0000_0000;
        case (reg_idx)
            `PRST_OFS_KEY: rd_nxt[7:0] = readback_key_r;
            `PRST_OFS_DATA: rd_nxt[WIDTH-1:0] = port_data_register_r;
            `PRST_OFS_DIR: rd_nxt[WIDTH-1:0] = port_direction_r;
            `PRST_OFS_PIN: rd_nxt[WIDTH-1:0] = pin_i;
            `PRST_OFS_READ: rd_nxt[WIDTH-1:0] = read_val;
            `PRST_OFS_BITOP: rd_nxt[3:0] = op_r;
            `PRST_OFS_ANSEL: rd_nxt[WIDTH-1:0] = ansel_r;
            `PRST_OFS_FUNC: rd_nxt[WIDTH-1:0] = serial_r;
            `PRST_OFS_CHAN: rd_nxt[WIDTH-1:0] = chan_sel_r;
            `PRST_OFS_WKEN: rd_nxt[WIDTH-1:0] = wake_en_r;
            `PRST_OFS_STAT: rd_nxt[1:0] = stat_r;
            `PRST_OFS_MASK: rd_nxt[1:0] = mask_r;
            `PRST_OFS_SLEEP: rd_nxt[0] = sleep_r;
            default: rd_nxt = 32'h0000_0000;
        endcase
    end

    // Bus handshake: a request is taken while ack is low and answered one cycle
    // later; the ack gate keeps a held request from being taken twice
    always @(posedge clk_i) begin
        if (rst_i) begin
            wb_ack_o <= 1'b0;
            wb_dat_o <= 32'h0000_0000;
        end else begin
            wb_ack_o <= acc_go;
            if (acc_go && !wb_we_i) begin
                wb_dat_o <= rd_nxt;
            end
        end
    end

    // Key register: any byte is stored and read back; only the pattern
    // enables readback, so software can check a failed unlock by reading
    always @(posedge clk_i) begin
        if (rst_i) begin
            readback_key_r <= `PRST_KEY_RESET;
        end else if (wr_go && reg_idx == `PRST_OFS_KEY) begin
            readback_key_r <= wb_dat_i[7:0];
        end
    end

    // Data latch: byte writes, and the write-back half of a bit op; the
    // write-back uses the whole port value, so digital input pins copy their level
    always @(posedge clk_i) begin
        if (rst_i) begin
            port_data_register_r <= `PRST_PORT_RESET;
        end else if (bitop_pend_r) begin
            port_data_register_r <= rmw_val;
        end else if (wr_go && reg_idx == `PRST_OFS_DATA) begin
            port_data_register_r <= wb_dat_i[WIDTH-1:0];
        end
    end

    // Sleep flag: software sets it, a wake event clears it; the wake wins a
    // tie so a falling edge is never lost behind a late sleep write
    always @(posedge clk_i) begin
        if (rst_i) begin
            sleep_r <= 1'b0;
        end else if (wake_evt) begin
            sleep_r <= 1'b0;
        end else if (wr_go && reg_idx == `PRST_OFS_SLEEP) begin
            sleep_r <= wb_dat_i[0];
        end
    end

    // Remaining control registers take plain byte writes
    always @(posedge clk_i) begin
        if (rst_i) begin
            port_direction_r <= `PRST_PORT_RESET;
            ansel_r <= {WIDTH{1'b0}};
            serial_r <= {WIDTH{1'b0}};
            chan_sel_r <= {WIDTH{1'b0}};
            wake_en_r <= {WIDTH{1'b0}};
            mask_r <= 2'h0;
            bit_idx_r <= 3'h0;
            bit_set_r <= 1'b0;
            op_r <= 4'h0;
        end else if (wr_go) begin
            case (reg_idx)
                `PRST_OFS_DIR: port_direction_r <= wb_dat_i[WIDTH-1:0];
                `PRST_OFS_BITOP: begin
                    // Write [2:0] bit, [3] set; the write-back follows one edge later
                    op_r <= wb_dat_i[3:0];
                    bit_idx_r <= wb_dat_i[2:0];
                    bit_set_r <= wb_dat_i[`PRST_BITOP_SET];
                end
                `PRST_OFS_ANSEL: ansel_r <= wb_dat_i[WIDTH-1:0];
                `PRST_OFS_FUNC: serial_r <= wb_dat_i[WIDTH-1:0];
                `PRST_OFS_CHAN: chan_sel_r <= wb_dat_i[WIDTH-1:0];
                `PRST_OFS_WKEN: wake_en_r <= wb_dat_i[WIDTH-1:0];
                `PRST_OFS_MASK: mask_r <= wb_dat_i[1:0];
                default: op_r <= op_r;
            endcase
        end
    end

    // Second phase of a bit op: writes the whole modified byte back
    always @(posedge clk_i) begin
        if (rst_i) begin
            bitop_pend_r <= 1'b0;
        end else begin
            bitop_pend_r <= wr_go && (reg_idx == `PRST_OFS_BITOP);
        end
    end

    // Pin drivers follow the latch; analog pins never drive, so the path sees the pin
    always @(posedge clk_i) begin
        if (rst_i) begin
            pin_o <= `PRST_PORT_RESET;
            pin_oe_o <= {WIDTH{1'b0}};
        end else begin
            pin_o <= port_data_register_r;
            pin_oe_o <= ~port_direction_r & ~ansel_r;
        end
    end

    // Analog switches and enable flag are registered copies of the decode
    always @(posedge clk_i) begin
        if (rst_i) begin
            ana_close_o <= {WIDTH{1'b0}};
            readback_enable_o <= 1'b0;
        end else begin
            ana_close_o <= close_w;
            readback_enable_o <= readback_enable;
        end
    end

    // Status, interrupt and wake pulse; irq follows the next status value so
    // that it rises with the status bit and not one cycle after it
    always @(posedge clk_i) begin
        if (rst_i) begin
            wake_o <= 1'b0;
            irq_o <= 1'b0;
            stat_r <= 2'h0;
        end else begin
            wake_o <= wake_evt;
            stat_r <= stat_nxt;
            irq_o <= |(stat_nxt & mask_r);
        end
    end

    // Pin history for falling-edge detect; reset to all ones so pins that
    // idle high give no false edge after reset
    always @(posedge clk_i) begin
        if (rst_i) begin
            pin_prev_r <= {WIDTH{1'b1}};
        end else begin
            pin_prev_r <= pin_i;
        end
    end
endmodule

// ### prst_props_properties.sv
// Checker for prst_top: bus handshake, key decode, reset state.
// Assumes it is bound to prst_top and sees only its ports.
`timescale 1ns/1ps
`include "prst_consts.vh"
module prst_props #(
    parameter WIDTH = 8
) (
    input wire clk_i,
    input wire rst_i,
    input wire wb_cyc_i,
    input wire wb_stb_i,
    input wire wb_we_i,
    input wire [5:0] wb_adr_i,
    input wire [3:0] wb_sel_i,
    input wire [31:0] wb_dat_i,
    input wire [31:0] wb_dat_o,
    input wire wb_ack_o,
    input wire [WIDTH-1:0] pin_i,
    input wire [WIDTH-1:0] pin_o,
    input wire [WIDTH-1:0] pin_oe_o,
    input wire [WIDTH-1:0] ana_close_o,
    input wire readback_enable_o,
    input wire wake_o,
    input wire irq_o
);
    default clocking @(posedge clk_i); endclocking
    default disable iff (rst_i);
    // Writes land at the taking edge, so shadows follow that edge
    wire wr = wb_cyc_i && wb_stb_i && wb_we_i && !wb_ack_o && wb_sel_i[0];
    wire rd = wb_ack_o && !wb_we_i;
    logic [7:0] key_r;
    logic [WIDTH-1:0] data_r;
    always @(posedge clk_i) begin
        if (rst_i) begin
            key_r <= 8'h00;
            data_r <= '1;
        end else if (wr && wb_adr_i[5:2] == `PRST_OFS_KEY) begin
            key_r <= wb_dat_i[7:0];
        end else if (wr && wb_adr_i[5:2] == `PRST_OFS_DATA) begin
            data_r <= wb_dat_i[WIDTH-1:0];
        end
    end
    // Bit op shadow: the latch is rewritten from the port value, which this
    // checker cannot see, so the plain data check pauses until a byte write
    wire bop = wr && wb_adr_i[5:2] == `PRST_OFS_BITOP;
    logic bop_seen_r;
    logic [2:0] bidx_r;
    logic bval_r;
    always @(posedge clk_i) begin
        if (rst_i) begin
            bop_seen_r <= 1'b0;
            bidx_r <= 3'h0;
            bval_r <= 1'b0;
        end else if (bop) begin
            bop_seen_r <= 1'b1;
            bidx_r <= wb_dat_i[2:0];
            bval_r <= wb_dat_i[3];
        end else if (wr && wb_adr_i[5:2] == `PRST_OFS_DATA) begin
            bop_seen_r <= 1'b0;
        end
    end
    bitop_bit_a: assert property (bop |=> ##2 pin_o[bidx_r] == bval_r)
        else $error("bit op result");
    ack_pulse_a: assert property (wb_ack_o |=> !wb_ack_o) else $error("ack too long");
    ack_time_a: assert property (wb_cyc_i && wb_stb_i && !wb_ack_o |=> wb_ack_o)
        else $error("ack late");
    key_decode_a: assert property (readback_enable_o == ($past(key_r) == 8'hca))
        else $error("readback enable wrong");
    data_pin_a: assert property (!bop_seen_r && !$past(bop_seen_r) |-> pin_o == $past(data_r))
        else $error("pin level differs from data");
    reset_state_a: assert property (disable iff (1'b0) rst_i |=>
        pin_o == '1 && pin_oe_o == '0 && !readback_enable_o && !irq_o) else $error("reset state");
    wake_pulse_a: assert property (wake_o |=> !wake_o) else $error("wake too long");
    rb_read_a: assert property (rd && wb_adr_i[5:2] == `PRST_OFS_READ && readback_enable_o
        |-> wb_dat_o[7:0] == $past(pin_i)) else $error("readback value");
    upper_zero_a: assert property (rd |-> wb_dat_o[31:8] == 24'h0) else $error("upper bits");
    cover property (rd && readback_enable_o);
    cover property (wake_o);
    cover property (irq_o);
endmodule

// ### prst_board.sv
// Board model at the port pins.
// Assumes ext_i is what outside circuits put on released pins.
`timescale 1ns/1ps
module prst_board (
    input wire [7:0] drv_i,
    input wire [7:0] oe_i,
    input wire [7:0] ext_i,
    output wire [7:0] level_o
);
    // Driven pins show the port, released pins the board
    assign level_o = (oe_i & drv_i) | (~oe_i & ext_i);
endmodule

// ### prst_tb.sv
// Testbench for prst_top with board model and bound checker.
// Assumes a single 40 MHz clock and synchronous reset.
`timescale 1ns/1ps
`include "prst_consts.vh"
`define CHK(g, e) begin n_tests++; if ((g) !== (e)) begin num_errors++; \
    $display("mismatch at %0t: got %h want %h", $time, g, e); end end
module testbench;
    logic clk_i = 0, rst_i = 1, cyc = 0, stb = 0, we = 0, ack, rb_en, wake, irq;
    logic [5:0] adr = 0;
    logic [31:0] wdat = 0, rdat;
    logic [7:0] pin_in, pin_out, oe, ana, q, ext = 8'h3c;
    int num_errors = 0, n_tests = 0, k;
    // Row: write index, write data, read index, expected read
    logic [23:0] rows [8] = '{24'h0ca0ca, 24'h035035, 24'h15a15a, 24'h20045a,
        24'h2ff43c, 24'h6ff400, 24'h0ca43c, 24'h0cb400};
    always #12.5 clk_i = ~clk_i;
    prst_top #(.WIDTH(8)) prst_top_i (.clk_i(clk_i), .rst_i(rst_i), .wb_cyc_i(cyc),
        .wb_stb_i(stb), .wb_we_i(we), .wb_adr_i(adr), .wb_sel_i(4'h1), .wb_dat_i(wdat),
        .wb_dat_o(rdat), .wb_ack_o(ack), .pin_i(pin_in), .pin_o(pin_out), .pin_oe_o(oe),
        .ana_close_o(ana), .readback_enable_o(rb_en), .wake_o(wake), .irq_o(irq));
    prst_board prst_board_i (.drv_i(pin_out), .oe_i(oe), .ext_i(ext), .level_o(pin_in));
    task automatic end_of_test;
        $display("compared %0d, mismatched %0d", n_tests, num_errors);
        if (num_errors == 0 && n_tests > 0)
            $display("Regression OK");
        else
            $display("Regression broken");
        $finish;
    endtask
    // One classic cycle; holds until ack is seen, one idle cycle follows
    task automatic bus(input logic w, input logic [3:0] idx, input logic [7:0] d);
        int n;
        n = 0;
        @(posedge clk_i);
        cyc <= 1;
        stb <= 1;
        we <= w;
        adr <= {idx, 2'b00};
        wdat <= {24'h0, d};
        do begin @(posedge clk_i); n++; end while (ack !== 1'b1 && n < 20);
        if (n >= 20) num_errors++;
        q = rdat[7:0];
        cyc <= 0;
        stb <= 0;
    endtask
    task automatic settle;
        repeat (3) @(posedge clk_i);
    endtask
    initial begin
        #100000;
        num_errors++;
        end_of_test();
    end
    initial begin
        repeat (8) @(posedge clk_i);
        rst_i <= 0;
        bus(0, `PRST_OFS_DATA, 0); `CHK(q, 8'hff)
        bus(0, `PRST_OFS_DIR, 0); `CHK(q, 8'hff)
        bus(0, `PRST_OFS_KEY, 0); `CHK(q, 8'h00)
        `CHK(pin_out, 8'hff)
        `CHK(oe, 8'h00)
        $display("reset test done");
        foreach (rows[i]) begin
            bus(1, rows[i][23:20], rows[i][19:12]);
            bus(0, rows[i][11:8], 0);
            `CHK(q, rows[i][7:0])
        end
        bus(0, 4'hf, 0); `CHK(q, 8'h00)
        $display("table test done");
        // Bit ops: set from the latch as output, clear from the pins as input
        bus(1, `PRST_OFS_ANSEL, 0);
        bus(1, `PRST_OFS_DIR, 0);
        bus(1, `PRST_OFS_BITOP, 8'h08);
        bus(0, `PRST_OFS_DATA, 0); `CHK(q, 8'h5b)
        `CHK(pin_out, 8'h5b)
        `CHK(oe, 8'hff)
        bus(1, `PRST_OFS_DIR, 8'hff);
        bus(1, `PRST_OFS_BITOP, 8'h02);
        bus(0, `PRST_OFS_DATA, 0); `CHK(q, 8'h38)
        $display("bit op test done");
        // Forced analog path, then the normal selection rule
        bus(1, `PRST_OFS_ANSEL, 0);
        bus(1, `PRST_OFS_CHAN, 8'h01);
        bus(1, `PRST_OFS_KEY, 8'hca);
        settle(); `CHK(ana, 8'h01)
        `CHK(rb_en, 1'b1)
        bus(1, `PRST_OFS_KEY, 0);
        settle(); `CHK(ana, 8'h00)
        `CHK(rb_en, 1'b0)
        bus(1, `PRST_OFS_ANSEL, 8'h01);
        settle(); `CHK(ana, 8'h01)
        $display("analog test done");
        // Wake on a falling pin edge, then mask and clear the interrupt
        bus(1, `PRST_OFS_WKEN, 8'h04);
        bus(1, `PRST_OFS_STAT, 8'h03);
        bus(1, `PRST_OFS_MASK, 8'h01);
        bus(1, `PRST_OFS_SLEEP, 8'h01);
        settle(); `CHK(irq, 1'b0)
        ext <= 8'h38;
        for (k = 0; k < 10 && wake !== 1'b1; k++) @(posedge clk_i);
        `CHK(wake, 1'b1)
        settle(); `CHK(irq, 1'b1)
        bus(0, `PRST_OFS_STAT, 0); `CHK(q[0], 1'b1)
        bus(1, `PRST_OFS_MASK, 0);
        settle(); `CHK(irq, 1'b0)
        bus(1, `PRST_OFS_STAT, 8'h01);
        bus(1, `PRST_OFS_MASK, 8'h01);
        settle(); `CHK(irq, 1'b0)
        $display("wake test done");
        rst_i <= 1;
        repeat (2) @(posedge clk_i);
        rst_i <= 0;
        bus(0, `PRST_OFS_DATA, 0); `CHK(q, 8'hff)
        $display("second reset test done");
        end_of_test();
    end
endmodule
bind prst_top prst_props #(.WIDTH(WIDTH)) prst_props_i (.clk_i(clk_i), .rst_i(rst_i),
    .wb_cyc_i(wb_cyc_i), .wb_stb_i(wb_stb_i), .wb_we_i(wb_we_i), .wb_adr_i(wb_adr_i),
    .wb_sel_i(wb_sel_i), .wb_dat_i(wb_dat_i), .wb_dat_o(wb_dat_o), .wb_ack_o(wb_ack_o),
    .pin_i(pin_i), .pin_o(pin_o), .pin_oe_o(pin_oe_o), .ana_close_o(ana_close_o),
    .readback_enable_o(readback_enable_o), .wake_o(wake_o), .irq_o(irq_o));
